// [shared/host_port_params.svh]
// timing and encoding constants for the card host port
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH
`define MODE_MEMORY   2'h0
`define MODE_IO       2'h1
`define MODE_IDE      2'h2
`define LOW_LANE_HI   7
`define LOW_LANES     16'h00FF
`define ALL_LANES     16'hFFFF
`define DATA_W        16
`define SYNC_W        2
`endif

// [shared/host_port_pkg.sv]
// types shared by the card host port
`default_nettype none
package host_port_pkg;
	typedef enum logic [1:0] {
		mode_memory = 2'h0,
		mode_io     = 2'h1,
		mode_ide    = 2'h2
	} card_mode_t;
	typedef struct packed {
		logic task_file_select_n;
		logic control_block_select_n;
		logic io_read_strobe_n;
		logic io_write_strobe_n;
		logic dma_acknowledge_n;
		logic card_select_n;
	} host_ctl_t;
	typedef struct packed {
		logic [15:0] data_out;
		logic [15:0] data_oe;
	} bus_drive_t;
endpackage
`default_nettype wire

// [hw/storage_card_host_port_pins.sv]
// pin-level host port logic: role select, lanes, input ack, dma request
//
// Overview of operation
// - ide mode: role pin low means master
// - d00 even byte lsb, d08 odd
// - ide register accesses use low byte only
// - ide data transfers use all sixteen lanes
// - input ack only on selected io read
// - memory mode: no input ack, ignore read
// - ide: request dma when data ready
// - hold request until host acknowledges
// - request undriven when drive not selected
// - task file and control block selects
`timescale 1ns/1ps
`default_nettype none
`include "host_port_params.svh"
module storage_card_host_port_pins (
	input  wire logic                      clk,
	input  wire logic                      nrst,
	input  wire host_port_pkg::card_mode_t mode,
	input  wire logic                      drive_role_select_n,
	input  wire host_port_pkg::host_ctl_t  host_ctl,
	input  wire logic                      drive_selected,
	input  wire logic                      io_addr_match,
	input  wire logic                      data_ready,
	input  wire logic [15:0]               read_word,
	input  wire logic [15:0]               data_in,
	output logic                           is_master,
	output logic                           input_acknowledge_n,
	output logic                           input_acknowledge_oe,
	output logic                           dma_request,
	output logic                           dma_request_oe,
	output logic                           dma_ack_seen,
	output host_port_pkg::bus_drive_t      bus_drive,
	output logic                           reg_write,
	output logic                           data_write,
	output logic [15:0]                    write_word
);
	import host_port_pkg::*;

	host_ctl_t  sync1;
	host_ctl_t  sync2;
	host_ctl_t  prev;
	logic       role1;
	logic       role2;

	// two flops per control; first stage read only by the second
	// strobes shorter than one clock can slip past unseen
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sync1 <= '1;
			sync2 <= '1;
			prev  <= '1;
			role1 <= 1'b1;
			role2 <= 1'b1;
		end else begin
			sync1 <= host_ctl;
			sync2 <= sync1;
			prev  <= sync2;
			role1 <= drive_role_select_n;
			role2 <= role1;
		end
	end

	logic io_rd;
	logic reg_sel;
	logic dma_acknowledge;
	logic wr_rise;
	assign io_rd   = !sync2.io_read_strobe_n;
	assign reg_sel = !sync2.task_file_select_n || !sync2.control_block_select_n;
	assign dma_acknowledge   = !sync2.dma_acknowledge_n;
	// writes land on the trailing (rising) edge of the strobe
	assign wr_rise = sync2.io_write_strobe_n && !prev.io_write_strobe_n;

	typedef enum logic [1:0] {dma_idle, dma_req, dma_wait} dma_state_t;
	dma_state_t state;
	dma_state_t next_state;

	logic       next_master;
	logic       next_inack;
	logic       next_inack_oe;
	logic       next_req;
	logic       next_req_oe;
	bus_drive_t next_bus;
	logic       next_reg_write;
	logic       next_data_write;
	logic [15:0] next_write_word;

	always_comb begin
		next_state      = state;
		next_master     = is_master;
		next_inack      = 1'b1;
		next_inack_oe   = 1'b0;
		next_bus        = '0;
		next_reg_write  = 1'b0;
		next_data_write = 1'b0;
		next_write_word = write_word;
		if (mode == mode_ide) begin
			next_master = !role2;
		end
		// io mode only; memory mode leaves it idle and ignores the read strobe
		if (mode == mode_io && !sync2.card_select_n && io_rd && io_addr_match) begin
			next_inack    = 1'b0;
			next_inack_oe = 1'b1;
		end
		if (mode != mode_memory && io_rd && (reg_sel || (mode == mode_ide && dma_acknowledge))) begin
			next_bus.data_out = read_word;
			if (mode == mode_ide && !dma_acknowledge) begin
				next_bus.data_oe = `LOW_LANES;
			end else begin
				next_bus.data_oe = `ALL_LANES;
			end
		end
		if (mode != mode_memory && wr_rise) begin
			if (mode == mode_ide && !dma_acknowledge && reg_sel) begin
				next_reg_write  = 1'b1;
				next_write_word = {8'h00, data_in[`LOW_LANE_HI:0]};
			end else if (dma_acknowledge || mode == mode_io) begin
				next_data_write = 1'b1;
				next_write_word = data_in;
			end
		end
		unique case (state)
			dma_idle: begin
				if (mode == mode_ide && data_ready) begin
					next_state = dma_req;
				end
			end
			dma_req: begin
				// held regardless of data_ready until the host acknowledges
				if (dma_acknowledge) begin
					next_state = dma_wait;
				end
			end
			dma_wait: begin
				if (!dma_acknowledge) begin
					next_state = dma_idle;
				end
			end
		endcase
		if (mode != mode_ide) begin
			next_state = dma_idle;
		end
		next_req    = (next_state == dma_req);
		next_req_oe = (mode == mode_ide) && drive_selected;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state                <= dma_idle;
			is_master            <= 1'b0;
			input_acknowledge_n  <= 1'b1;
			input_acknowledge_oe <= 1'b0;
			dma_request          <= 1'b0;
			dma_request_oe       <= 1'b0;
			dma_ack_seen         <= 1'b0;
			bus_drive            <= '0;
			reg_write            <= 1'b0;
			data_write           <= 1'b0;
			write_word           <= 16'h0000;
		end else begin
			state                <= next_state;
			is_master            <= next_master;
			input_acknowledge_n  <= next_inack;
			input_acknowledge_oe <= next_inack_oe;
			dma_request          <= next_req;
			dma_request_oe       <= next_req_oe;
			dma_ack_seen         <= dma_acknowledge;
			bus_drive            <= next_bus;
			reg_write            <= next_reg_write;
			data_write           <= next_data_write;
			write_word           <= next_write_word;
		end
	end

	sequence s_req_up;
		!dma_request ##1 dma_request;
	endsequence
	a_req_hold: assert property (@(posedge clk) disable iff (!nrst)
		(dma_request && !dma_ack_seen && mode == mode_ide) |=> dma_request || dma_ack_seen)
		else $error("dma request dropped before acknowledge");
	a_req_cause: assert property (@(posedge clk) disable iff (!nrst)
		s_req_up |-> $past(mode) == mode_ide)
		else $error("dma request outside ide mode");
	a_req_float: assert property (@(posedge clk) disable iff (!nrst)
		dma_request_oe |-> $past(drive_selected))
		else $error("dma request driven while not selected");
	a_inack_io: assert property (@(posedge clk) disable iff (!nrst)
		!input_acknowledge_n |-> $past(mode) == mode_io && $past(io_rd) && $past(io_addr_match))
		else $error("input ack without selected io read");
	a_inack_mem: assert property (@(posedge clk) disable iff (!nrst)
		$past(mode) == mode_memory |-> input_acknowledge_n && !input_acknowledge_oe)
		else $error("input ack used in memory mode");
	a_reg_lanes: assert property (@(posedge clk) disable iff (!nrst)
		reg_write |-> write_word[15:8] == 8'h00)
		else $error("register write beyond low lanes");
	a_dma_width: assert property (@(posedge clk) disable iff (!nrst)
		($past(mode) == mode_ide && $past(dma_acknowledge) && bus_drive.data_oe != '0)
		|-> bus_drive.data_oe == 16'hFFFF)
		else $error("dma read not full width");
	a_role_pin: assert property (@(posedge clk) disable iff (!nrst)
		($past(mode) == mode_ide && $past(role2) == 1'b0) |-> is_master)
		else $error("grounded role pin did not give master");
	a_reg_read: assert property (@(posedge clk) disable iff (!nrst)
		($past(mode) == mode_ide && !$past(dma_acknowledge) && bus_drive.data_oe != '0)
		|-> bus_drive.data_oe == `LOW_LANES)
		else $error("register read beyond low lanes");

	sequence s_write_edge;
		!sync2.io_write_strobe_n ##1 sync2.io_write_strobe_n;
	endsequence
	a_write_edge: assert property (@(posedge clk) disable iff (!nrst)
		(s_write_edge ##0 (mode == mode_io)) |=> data_write)
		else $error("io write edge gave no data write");
	a_write_pulse: assert property (@(posedge clk) disable iff (!nrst)
		data_write |=> !data_write)
		else $error("data write longer than one cycle");
endmodule // storage_card_host_port_pins
`default_nettype wire

// [tb/host_dma_model.sv]
// host side model answering dma requests
`timescale 1ns/1ps
`default_nettype none
module host_dma_model (
	input  wire logic       clk,
	input  wire logic       dma_request,
	input  wire logic       dma_request_oe,
	input  wire logic [3:0] delay,
	input  wire logic       hold,
	output logic            dma_acknowledge_n
);
	logic [3:0] cnt;
	initial begin
		dma_acknowledge_n = 1'b1;
		cnt = 4'h0;
	end
	// ack stays low through a transfer while hold is up; otherwise an idle
	// or released request line ends it
	always @(negedge clk) begin
		if (dma_request_oe === 1'b1 && dma_request === 1'b1) begin
			if (cnt >= delay) begin
				dma_acknowledge_n <= 1'b0;
			end else begin
				cnt <= cnt + 4'h1;
			end
		end else if (hold !== 1'b1) begin
			dma_acknowledge_n <= 1'b1;
			cnt <= 4'h0;
		end
	end
endmodule // host_dma_model
`default_nettype wire

// [tb/storage_card_host_port_pins_bench.sv]
// bench for the card host port pins
`timescale 1ns/1ps
`default_nettype none
module storage_card_host_port_pins_bench;
	import host_port_pkg::*;
	logic       clk, nrst, role_n, sel, match, ready, ack_n, hold;
	logic       master, ia_n, ia_oe, rq, rq_oe, seen, rw, dw;
	logic [4:0] ctl;
	logic [3:0] delay;
	logic [15:0] din, ww;
	card_mode_t mode;
	host_ctl_t  hc;
	bus_drive_t bd;
	int         errors, checks;
	assign hc = {ctl[4:1], ack_n, ctl[0]};
	storage_card_host_port_pins storage_card_host_port_pins_i (.clk(clk), .nrst(nrst),
		.mode(mode), .drive_role_select_n(role_n), .host_ctl(hc), .drive_selected(sel),
		.io_addr_match(match), .data_ready(ready), .read_word(16'h5AC3), .data_in(din),
		.is_master(master), .input_acknowledge_n(ia_n), .input_acknowledge_oe(ia_oe),
		.dma_request(rq), .dma_request_oe(rq_oe), .dma_ack_seen(seen), .bus_drive(bd),
		.reg_write(rw), .data_write(dw), .write_word(ww));
	host_dma_model host_dma_model_i (.clk(clk), .dma_request(rq), .dma_request_oe(rq_oe),
		.delay(delay), .hold(hold), .dma_acknowledge_n(ack_n));
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic end_sim;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// bounded wait for the request level
	task automatic wait_rq(input logic v);
		int i;
		for (i = 0; i < 20 && rq !== v; i++)
			wt(1);
		if (rq !== v) begin
			errors++;
			end_sim;
		end
	endtask
	task automatic t_role;
		mode = mode_ide;
		role_n = 1'b0;
		wt(4);
		chk("master", 16'(master), 16'h1);
		role_n = 1'b1;
		wt(4);
		chk("slave", 16'(master), 16'h0);
		mode = mode_memory;
		role_n = 1'b0;
		wt(4);
		chk("role ignored", 16'(master), 16'h0);
	endtask
	task automatic t_inack;
		mode = mode_io;
		match = 1'b1;
		ctl = 5'h1A;
		wt(4);
		chk("inack", 16'({ia_n, ia_oe}), 16'h1);
		match = 1'b0;
		wt(4);
		chk("inack other addr", 16'(ia_n), 16'h1);
		mode = mode_memory;
		match = 1'b1;
		wt(4);
		chk("inack memory", 16'({ia_n, ia_oe}), 16'h2);
		ctl = 5'h1F;
		wt(4);
	endtask
	task automatic t_dma(input logic [3:0] d);
		mode = mode_ide;
		sel = 1'b1;
		delay = d;
		ready = 1'b1;
		wait_rq(1'b1);
		ready = 1'b0;
		chk("rq_oe", 16'(rq_oe), 16'h1);
		wt(int'(d));
		chk("rq held", 16'(rq), 16'h1);
		wait_rq(1'b0);
		chk("ack seen", 16'(seen), 16'h1);
		sel = 1'b0;
		wt(4);
		chk("rq released", 16'(rq_oe), 16'h0);
	endtask
	task automatic t_write;
		mode = mode_ide;
		din = 16'hA5C3;
		ctl = 5'h0B;
		wt(4);
		chk("reg read lanes", bd.data_oe, 16'h00FF);
		chk("reg read word", bd.data_out, 16'h5AC3);
		ctl = 5'h0D;
		wt(4);
		ctl = 5'h0F;
		wt(3);
		chk("reg write", {rw, ww[14:0]}, 16'h80C3);
		chk("reg high", ww, 16'h00C3);
		mode = mode_io;
		ctl = 5'h1C;
		wt(4);
		ctl = 5'h1E;
		wt(3);
		chk("data write", 16'(dw), 16'h1);
		chk("data word", ww, 16'hA5C3);
	endtask
	// host keeps both selects negated and moves whole words under ack
	task automatic t_dma_xfer;
		mode = mode_ide;
		sel = 1'b1;
		delay = 4'h0;
		hold = 1'b1;
		ready = 1'b1;
		ctl = 5'h1F;
		din = 16'h3C5A;
		wait_rq(1'b1);
		ready = 1'b0;
		wait_rq(1'b0);
		chk("xfer ack seen", 16'(seen), 16'h1);
		ctl = 5'h1B;
		wt(4);
		chk("dma read lanes", bd.data_oe, 16'hFFFF);
		chk("dma read word", bd.data_out, 16'h5AC3);
		chk("dma no inack", 16'(ia_n), 16'h1);
		ctl = 5'h1F;
		wt(4);
		ctl = 5'h1D;
		wt(4);
		ctl = 5'h1F;
		wt(3);
		chk("dma write", 16'({rw, dw}), 16'h1);
		chk("dma word", ww, 16'h3C5A);
		hold = 1'b0;
		wt(6);
		chk("ack released", 16'({seen, rq}), 16'h0);
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// selects stay negated during dma
	initial begin
		{errors, checks} = 0;
		{nrst, sel, match, ready, din, delay, hold} = '0;
		{role_n, ctl} = '1;
		mode = mode_memory;
		wt(3);
		nrst = 1'b1;
		wt(1);
		chk("reset", 16'({ia_n, rq_oe, rq}), 16'h4);
		t_role;
		t_inack;
		t_dma(4'h0);
		t_dma(4'h6);
		t_write;
		t_dma_xfer;
		end_sim;
	end
endmodule // storage_card_host_port_pins_bench
`default_nettype wire
